/* File: rtl/rig_pkg.sv */
// Purpose: Shared constants and types for the read-back integrity byte ends.
// Assumes: Byte-wide stream between the converter end and the host end.
// Notes: Both ends compute the same byte from the same constants.
package rig_pkg;
	// ==========================================================
	// Integrity mode field
	// ==========================================================
	typedef enum logic [1:0] {
		RIG_MODE_OFF = 2'b00,
		RIG_MODE_SUM = 2'b01,
		RIG_MODE_CRC = 2'b10,
		RIG_MODE_RSV = 2'b11
	} rig_mode_t;

	// ==========================================================
	// Arithmetic constants
	// ==========================================================
	localparam logic [7:0] RIG_SUM_OFFSET = 8'h9b;
	localparam logic [8:0] RIG_CRC_POLY = 9'h107;
	localparam logic [7:0] RIG_CRC_INIT = 8'h00;
	localparam int RIG_PRI_BYTES = 4;
	localparam int RIG_AUX_BYTES = 3;

	// ==========================================================
	// Per-byte updates, most significant bit first
	// ==========================================================
	function automatic logic [7:0] rig_crc_byte(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc ^ d;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ RIG_CRC_POLY[7:0]) : (c << 1);
		end
		return c;
	endfunction

	function automatic logic [7:0] rig_next(input rig_mode_t mode, input logic [7:0] acc,
		input logic [7:0] d);
		if (mode == RIG_MODE_CRC) begin
			return rig_crc_byte(acc, d);
		end
		return acc + d;
	endfunction

	function automatic logic [7:0] rig_seed(input rig_mode_t mode);
		return (mode == RIG_MODE_CRC) ? RIG_CRC_INIT : RIG_SUM_OFFSET;
	endfunction
endpackage

/* File: rtl/rig_link_if.sv */
// Purpose: Byte stream from converter end to host end.
// Assumes: One clock shared by both ends.
// Notes: A byte moves on a cycle with valid and ready both high.
interface rig_link_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	logic last;
	logic isCheck;

	modport dev (output data, output valid, input ready, output last, output isCheck);
	modport host (input data, input valid, output ready, input last, input isCheck);
endinterface

/* File: rtl/rig_device_end.sv */
// Purpose: Sends conversion or register bytes and appends the integrity byte to conversion reads.
// Assumes: Request fields are stable while reqValid and reqReady are both high.
// Notes: The byte is computed serially as data bytes leave.
// ==========================================================
module rig_device_end (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Request
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqIsReg,
	input wire logic reqAux,
	input wire logic [31:0] reqData,
	input wire logic [1:0] modeSel,
	// Link
	rig_link_if.dev link
);
	// ==========================================================
	// State
	// ==========================================================
	typedef enum logic [1:0] {
		RIG_S_IDLE = 2'b00,
		RIG_S_DATA = 2'b01,
		RIG_S_CHK = 2'b10
	} rig_dstate_t;

	rig_dstate_t state_r;
	rig_dstate_t state_nxt;
	logic [31:0] shift_r;
	logic [2:0] left_r;
	logic [7:0] acc_r;
	logic [7:0] acc_nxt;
	logic [7:0] out_r;
	logic outLast_r;
	logic outCheck_r;
	logic chkOn_r;
	rig_pkg::rig_mode_t mode_r;
	logic take;
	logic fire;
	logic dataFire;
	logic atFinal;
	logic finalFire;
	logic chkSel;

	// ==========================================================
	// Request decode
	// ==========================================================
	// Conversion bytes in one read-back.
	function automatic logic [2:0] frameBytes(input logic aux);
		return aux ? 3'(rig_pkg::RIG_AUX_BYTES) : 3'(rig_pkg::RIG_PRI_BYTES);
	endfunction

	// Only checksum and CRC modes on a conversion read append a byte.
	function automatic logic checkWanted(input logic isReg, input logic [1:0] mode);
		logic modeOn;
		modeOn = (mode == rig_pkg::RIG_MODE_SUM) || (mode == rig_pkg::RIG_MODE_CRC);
		return modeOn && !isReg;
	endfunction

	assign reqReady = (state_r == RIG_S_IDLE);
	assign take = reqValid && reqReady;
	assign fire = link.valid && link.ready;
	assign dataFire = fire && (state_r == RIG_S_DATA);
	assign atFinal = (state_r == RIG_S_DATA) && (left_r == 3'd1);
	assign finalFire = fire && atFinal;
	// Reserved mode 11 is not programmed; it is treated as off here.
	assign chkSel = checkWanted(reqIsReg, modeSel);

	// ==========================================================
	// Link outputs
	// ==========================================================
	// Data, last and check marker come from registers; only valid follows the state.
	assign link.valid = (state_r != RIG_S_IDLE);
	assign link.data = out_r;
	assign link.isCheck = outCheck_r;
	assign link.last = outLast_r;

	// ==========================================================
	// Sequencer
	// ==========================================================
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RIG_S_IDLE: begin
				if (take) begin
					state_nxt = RIG_S_DATA;
				end
			end
			RIG_S_DATA: begin
				if (finalFire) begin
					state_nxt = chkOn_r ? RIG_S_CHK : RIG_S_IDLE;
				end
			end
			RIG_S_CHK: begin
				if (fire) begin
					state_nxt = RIG_S_IDLE;
				end
			end
			default: begin
				state_nxt = RIG_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= RIG_S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Byte counter
	// ==========================================================
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			left_r <= 3'd0;
		end else if (take) begin
			left_r <= frameBytes(reqAux);
		end else if (dataFire) begin
			left_r <= left_r - 3'd1;
		end
	end

	// ==========================================================
	// Request capture
	// ==========================================================
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chkOn_r <= 1'b0;
			mode_r <= rig_pkg::RIG_MODE_OFF;
		end else if (take) begin
			chkOn_r <= chkSel;
			mode_r <= rig_pkg::rig_mode_t'(modeSel);
		end
	end

	// ==========================================================
	// Data shifter, most significant byte first
	// ==========================================================
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_r <= 32'h0;
		end else if (take) begin
			shift_r <= reqAux ? {reqData[23:0], 8'h00} : reqData;
		end else if (dataFire) begin
			shift_r <= {shift_r[23:0], 8'h00};
		end
	end

	// ==========================================================
	// Integrity accumulator
	// ==========================================================
	// Bytewise CRC from zero equals the long division of data followed by eight zeros.
	assign acc_nxt = rig_pkg::rig_next(mode_r, acc_r, shift_r[31:24]);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_r <= 8'h00;
		end else if (take) begin
			acc_r <= rig_pkg::rig_seed(rig_pkg::rig_mode_t'(modeSel));
		end else if (dataFire) begin
			acc_r <= acc_nxt;
		end
	end

	// ==========================================================
	// Output byte
	// ==========================================================
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_r <= 8'h00;
		end else if (take) begin
			out_r <= reqAux ? reqData[23:16] : reqData[31:24];
		end else if (finalFire) begin
			out_r <= acc_nxt;
		end else if (dataFire) begin
			out_r <= shift_r[23:16];
		end
	end

	// ==========================================================
	// Frame markers
	// ==========================================================
	// Markers are set one byte ahead so they stand with the byte they describe.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			outCheck_r <= 1'b0;
			outLast_r <= 1'b0;
		end else if (take) begin
			outCheck_r <= 1'b0;
			outLast_r <= 1'b0;
		end else if (dataFire && left_r == 3'd2) begin
			outLast_r <= !chkOn_r;
		end else if (finalFire) begin
			outCheck_r <= chkOn_r;
			outLast_r <= chkOn_r;
		end else if (fire) begin
			outCheck_r <= 1'b0;
			outLast_r <= 1'b0;
		end
	end
endmodule

/* File: rtl/rig_host_end.sv */
// Purpose: Receives a read-back and checks the integrity byte.
// Assumes: The host knows the mode it programmed; the frame end comes from the last marker.
// Notes: A mismatch raises retryReq for one cycle so the read is repeated.
module rig_host_end (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Setup
	input wire logic [1:0] modeSel,
	// Result
	output logic [31:0] rxData,
	output logic rxDone,
	output logic rxOk,
	output logic retryReq,
	// Link
	rig_link_if.host link
);
	logic [31:0] data_r;
	logic [7:0] acc_r;
	logic first_r;
	logic fire;
	logic [7:0] seed;

	assign link.ready = 1'b1;
	assign fire = link.valid && link.ready;
	assign seed = rig_pkg::rig_seed(rig_pkg::rig_mode_t'(modeSel));

	// ==========================================================
	// Running check, excluding the received integrity byte
	// ==========================================================
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_r <= 8'h00;
			data_r <= 32'h0;
			first_r <= 1'b1;
		end else if (fire) begin
			first_r <= link.last;
			if (!link.isCheck) begin
				acc_r <= rig_pkg::rig_next(rig_pkg::rig_mode_t'(modeSel),
					first_r ? seed : acc_r, link.data);
				data_r <= first_r ? {24'h0, link.data} : {data_r[23:0], link.data};
			end
		end
	end

	// ==========================================================
	// Result
	// ==========================================================
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxData <= 32'h0;
			rxDone <= 1'b0;
			rxOk <= 1'b0;
			retryReq <= 1'b0;
		end else begin
			rxDone <= fire && link.last;
			retryReq <= fire && link.isCheck && (link.data != acc_r);
			if (fire && link.last) begin
				rxData <= link.isCheck ? data_r : (first_r ? {24'h0, link.data} : {data_r[23:0], link.data});
				rxOk <= !link.isCheck || (link.data == acc_r);
			end
		end
	end
endmodule

/* File: verif/rig_asserts.sv */
// Purpose: Link checks for the integrity byte stream.
// Assumes: Host end keeps ready high.
// Notes: Counts bytes taken in each frame.
module rig_asserts (
	// Clock, reset and link
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] data,
	input wire logic valid,
	input wire logic ready,
	input wire logic last,
	input wire logic isCheck
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_r;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) cnt_r <= 3'h0;
		else if (valid && ready) cnt_r <= last ? 3'h0 : cnt_r + 3'h1;
	end
	a_check_is_last: assert property (valid && isCheck |-> last)
		else $error("check byte not last");
	a_check_follows: assert property (valid && isCheck |-> $past(valid))
		else $error("check byte without data before it");
	a_check_count: assert property (valid && ready && isCheck |-> cnt_r inside {3'h3, 3'h4})
		else $error("wrong bytes before check");
	a_plain_count: assert property (valid && ready && last && !isCheck |-> cnt_r inside {3'h2, 3'h3})
		else $error("wrong plain frame length");
	a_gap_after: assert property (valid && ready && last |=> !valid)
		else $error("no idle after frame");
	a_burst_min: assert property ($rose(valid) |-> valid[*3])
		else $error("frame too short");
	a_frame_end: assert property ($rose(valid) |-> ##[2:4] (valid && last))
		else $error("frame end late");
	a_reset_idle: assert property ($rose(arst_n) |-> !valid)
		else $error("valid after reset");
endmodule

/* File: verif/readback_integrity_byte_gen_bench.sv */
// Purpose: Self-checking bench for both link ends.
// Assumes: Host ready always high.
// Notes: Host mode may differ to force a retry.
module readback_integrity_byte_gen_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ====================================
	// Stimulus and table
	// ====================================
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reqValid = 1'b0;
	logic reqIsReg = 1'b0;
	logic reqAux = 1'b0;
	logic [31:0] reqData = 32'h0;
	logic [1:0] devMode = 2'h0;
	logic [1:0] hostMode = 2'h0;
	logic reqReady, rxDone, rxOk, retryReq;
	logic [31:0] rxData;
	logic [31:0] word;
	logic [7:0] seen[$];
	logic [7:0] expByte;
	int nErrors = 0;
	int checksDone = 0;
	// Columns are mode, aux, register read, data.
	localparam logic [35:0] ROWS [7] = '{{4'h4, 32'h12345678}, {4'h8, 32'h12345678},
		{4'h6, 32'h00abcdef}, {4'ha, 32'h00fedcba}, {4'h0, 32'h80000001},
		{4'hc, 32'h00000000}, {4'h9, 32'hdeadbeef}};
	rig_link_if link ();
	rig_device_end rig_device_end_inst (.sys_clk(sys_clk), .arst_n(arst_n), .reqValid(reqValid),
		.reqReady(reqReady), .reqIsReg(reqIsReg), .reqAux(reqAux), .reqData(reqData),
		.modeSel(devMode), .link(link.dev));
	rig_host_end rig_host_end_inst (.sys_clk(sys_clk), .arst_n(arst_n), .modeSel(hostMode),
		.rxData(rxData), .rxDone(rxDone), .rxOk(rxOk), .retryReq(retryReq), .link(link.host));
	rig_asserts rig_asserts_inst (.sys_clk(sys_clk), .arst_n(arst_n), .data(link.data),
		.valid(link.valid), .ready(link.ready), .last(link.last), .isCheck(link.isCheck));
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (link.valid && link.ready) seen.push_back(link.data);
	task check(input logic [39:0] got, input logic [39:0] exp);
		checksDone++;
		if (got !== exp) begin
			nErrors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Long division of the zero-extended value, top bit first.
	function automatic logic [7:0] crcRef(input logic [39:0] v, input int nb);
		for (int i = nb - 1; i >= 8; i--) if (v[i]) v = v ^ (40'h107 << (i - 8));
		return v[7:0];
	endfunction
	function automatic logic [7:0] refByte(input logic [1:0] m, input logic aux,
		input logic [31:0] d);
		logic [7:0] s;
		s = 8'h9b + d[7:0] + d[15:8] + d[23:16] + (aux ? 8'h00 : d[31:24]);
		return (m == 2'h2) ? crcRef({d, 8'h00}, aux ? 32 : 40) : s;
	endfunction
	task doReq(input logic [1:0] dm, input logic [1:0] hm, input logic aux, input logic isReg,
		input logic [31:0] d);
		seen = {};
		@(negedge sys_clk);
		devMode = dm;
		hostMode = hm;
		reqAux = aux;
		reqIsReg = isReg;
		reqData = d;
		reqValid = 1'b1;
		@(negedge sys_clk);
		reqValid = 1'b0;
		for (int i = 0; i < 20 && rxDone !== 1'b1; i++) @(negedge sys_clk);
		check(rxDone, 1'b1);
	endtask
	task endSim();
		if (nErrors == 0 && checksDone > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ====================================
	// Sequence
	// ====================================
	initial begin
		#100us;
		nErrors++;
		endSim();
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		check(reqReady, 1'b1);
		check(link.valid, 1'b0);
		arst_n = 1'b1;
		foreach (ROWS[r]) begin
			doReq(ROWS[r][35:34], ROWS[r][35:34], ROWS[r][33], ROWS[r][32], ROWS[r][31:0]);
			word = 32'h0;
			for (int k = 0; k < (ROWS[r][33] ? 3 : 4); k++) word = {word[23:0], seen[k]};
			check(word, ROWS[r][31:0]);
			check(rxData, ROWS[r][31:0]);
			check(rxOk, 1'b1);
			check(retryReq, 1'b0);
			if (ROWS[r][35:34] inside {2'h1, 2'h2} && !ROWS[r][32]) begin
				check(40'(seen.size()), ROWS[r][33] ? 4 : 5);
				expByte = refByte(ROWS[r][35:34], ROWS[r][33], ROWS[r][31:0]);
				check(seen[seen.size() - 1], expByte);
			end
			else check(40'(seen.size()), ROWS[r][33] ? 3 : 4);
		end
		// Host expects a checksum while a CRC arrives.
		doReq(2'h2, 2'h1, 1'b0, 1'b0, 32'h12345678);
		expByte = refByte(2'h1, 1'b0, 32'h12345678);
		check(retryReq, expByte != refByte(2'h2, 1'b0, 32'h12345678));
		check(rxOk, expByte == refByte(2'h2, 1'b0, 32'h12345678));
		check(rxData, 32'h12345678);
		// Reset in mid-frame drops the frame and leaves both ends idle.
		@(negedge sys_clk);
		devMode = 2'h1;
		reqValid = 1'b1;
		@(negedge sys_clk);
		reqValid = 1'b0;
		@(negedge sys_clk);
		arst_n = 1'b0;
		@(negedge sys_clk);
		check(link.valid, 1'b0);
		check(reqReady, 1'b1);
		check(rxDone, 1'b0);
		check(retryReq, 1'b0);
		check(rxData, 32'h0);
		arst_n = 1'b1;
		doReq(2'h1, 2'h1, 1'b1, 1'b0, 32'h00123456);
		check(rxData, 32'h00123456);
		check(rxOk, 1'b1);
		check(40'(seen.size()), 4);
		expByte = refByte(2'h1, 1'b1, 32'h00123456);
		check(seen[3], expByte);
		endSim();
	end
endmodule
